/* File: hdl/iarb_internal_bus_master_arbiter.sv */
module iarb_internal_bus_master_arbiter
    import iarb_pkg::*;
#(
    parameter int NUM_CH = 4,
    parameter int CH_W = 2,
    parameter int NUM_CS = 8,
    parameter int DW = 32
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [IARB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic core_req,
    input wire logic core_int_reg,
    input wire logic [NUM_CH-1:0] dma_ch_req,
    input wire logic [NUM_CH*IARB_BW_W-1:0] dma_bandwidth_control,
    input wire logic ext_req,
    input wire logic xfer_done,
    input wire logic external_bus_grant_in_n,
    output logic core_gnt,
    output logic dma_gnt,
    output logic [CH_W-1:0] dma_gnt_ch,
    output logic ext_gnt,
    output logic core_stall,
    input wire logic [DW-1:0] int_reg_data,
    output logic [DW-1:0] ext_data_out,
    output logic ext_data_oe,
    output logic transfer_acknowledge_n_out,
    output logic transfer_acknowledge_oe,
    input wire logic address_strobe_n_in,
    output logic address_strobe_n,
    input wire logic [NUM_CS-1:0] chip_select_n_in,
    output logic [NUM_CS-1:0] chip_select_n,
    output logic dma_count_width_select,
    output logic [23:0] dma_count_mask
);

    // Pick the DMA channel with the smallest bandwidth code; ties go low index
    function automatic logic [CH_W-1:0] top_channel(
        input logic [NUM_CH-1:0] req,
        input logic [NUM_CH*IARB_BW_W-1:0] bw
    );
        logic [CH_W-1:0] best;
        logic [IARB_BW_W-1:0] best_bw;
        logic found;
        best = '0;
        best_bw = '1;
        found = 1'b0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (req[i] && (!found || bw[i*IARB_BW_W +: IARB_BW_W] < best_bw))
            begin
                best = CH_W'(i);
                best_bw = bw[i*IARB_BW_W +: IARB_BW_W];
                found = 1'b1;
            end
        end
        return best;
    endfunction

    logic [7:0] ctrl_r;
    logic [31:0] prdata_r;
    iarb_owner_e owner_r;
    iarb_owner_e owner_nxt;
    logic active_r;
    logic last_dma_r;
    logic core_first_r;
    logic bg_negated_d_r;
    logic [CH_W-1:0] dma_ch_r;
    logic [DW-1:0] ext_data_r;
    logic [1:0] scheme;
    logic ext_arb_en;
    logic show_en;
    logic dma_req;
    logic [CH_W-1:0] dma_top;
    logic dma_max_bw;
    logic boundary;
    logic bg_negated;
    logic grant_back;
    logic core_first;
    logic int_xfer_ext;
    logic ctrl_hit;
    logic stat_hit;
    logic setup_rd;
    logic access_wr;

    // Control fields
    assign scheme = ctrl_r[IARB_SCHEME_HI:IARB_SCHEME_LO];
    assign ext_arb_en = ctrl_r[IARB_EXT_ARB_BIT];
    assign show_en = ctrl_r[IARB_SHOW_BIT];

    // APB decode; the slave never inserts wait states
    assign ctrl_hit = (paddr == IARB_CTRL_OFS);
    assign stat_hit = (paddr == IARB_STAT_OFS);
    assign setup_rd = psel && !penable && !pwrite;
    assign access_wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(ctrl_hit || stat_hit);
    assign prdata = prdata_r;

    // Control register write; reserved bits are dropped so they read zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= IARB_CTRL_RST;
        end
        else if (access_wr && ctrl_hit)
        begin
            ctrl_r <= pwdata[7:0] & IARB_CTRL_MASK;
        end
    end

    // Read data captured in setup so it is stable through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= '0;
        end
        else if (setup_rd)
        begin
            if (ctrl_hit)
            begin
                prdata_r <= {24'h000000, ctrl_r};
            end
            else if (stat_hit)
            begin
                prdata_r <= {27'h0000000, core_first_r, active_r, last_dma_r, owner_r};
            end
            else
            begin
                prdata_r <= '0;
            end
        end
    end

    // DMA side: one request, the top channel's
    assign dma_req = |dma_ch_req;
    assign dma_top = top_channel(dma_ch_req, dma_bandwidth_control);
    assign dma_max_bw = dma_bandwidth_control[dma_top*IARB_BW_W +: IARB_BW_W] == IARB_BW_MAX;

    // With arbitration off, a grant tied low or high never reaches the core/DMA choice
    assign bg_negated = ext_arb_en && external_bus_grant_in_n;
    assign boundary = !active_r || xfer_done;

    // Grant just came back: the core window opens in this very cycle
    assign grant_back = bg_negated_d_r && !bg_negated;
    assign core_first = core_first_r || grant_back;

    // Next owner, evaluated only where a transfer may start
    always_comb
    begin
        owner_nxt = owner_r;
        if (bg_negated)
        begin
            if (ext_req)
            begin
                owner_nxt = IARB_OWN_EXT;
            end
            else if (core_req)
            begin
                owner_nxt = IARB_OWN_CORE;
            end
            else if (dma_req)
            begin
                owner_nxt = IARB_OWN_DMA;
            end
        end
        else if (core_first && core_req)
        begin
            owner_nxt = IARB_OWN_CORE;
        end
        else if (core_req && dma_req && dma_max_bw && scheme != IARB_PARK_CURRENT)
        begin
            owner_nxt = IARB_OWN_DMA;
        end
        else
        begin
            case (scheme)
                IARB_ROUND_ROBIN:
                begin
                    if (core_req && dma_req)
                    begin
                        owner_nxt = last_dma_r ? IARB_OWN_CORE : IARB_OWN_DMA;
                    end
                    else if (core_req)
                    begin
                        owner_nxt = IARB_OWN_CORE;
                    end
                    else if (dma_req)
                    begin
                        owner_nxt = IARB_OWN_DMA;
                    end
                end
                IARB_PARK_CORE:
                begin
                    if (core_req)
                    begin
                        owner_nxt = IARB_OWN_CORE;
                    end
                    else if (dma_req)
                    begin
                        owner_nxt = IARB_OWN_DMA;
                    end
                end
                IARB_PARK_DMA:
                begin
                    if (dma_req)
                    begin
                        owner_nxt = IARB_OWN_DMA;
                    end
                    else if (core_req)
                    begin
                        owner_nxt = IARB_OWN_CORE;
                    end
                end
                IARB_PARK_CURRENT:
                begin
                    if (owner_r == IARB_OWN_DMA)
                    begin
                        if (!dma_req && core_req)
                        begin
                            owner_nxt = IARB_OWN_CORE;
                        end
                    end
                    else if (owner_r == IARB_OWN_CORE)
                    begin
                        if (!core_req && dma_req)
                        begin
                            owner_nxt = IARB_OWN_DMA;
                        end
                    end
                    else if (core_req)
                    begin
                        owner_nxt = IARB_OWN_CORE;
                    end
                    else if (dma_req)
                    begin
                        owner_nxt = IARB_OWN_DMA;
                    end
                end
                default:
                begin
                    owner_nxt = owner_r;
                end
            endcase
            if (owner_nxt == IARB_OWN_EXT)
            begin
                // External owner left with the grant back: hand to an idle-park master
                owner_nxt = dma_req ? IARB_OWN_DMA : IARB_OWN_CORE;
            end
        end
    end

    // Owner and transfer-in-progress tracking
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            owner_r <= IARB_OWN_CORE;
            active_r <= 1'b0;
        end
        else if (boundary)
        begin
            owner_r <= owner_nxt;
            case (owner_nxt)
                IARB_OWN_CORE: active_r <= core_req;
                IARB_OWN_DMA: active_r <= dma_req;
                IARB_OWN_EXT: active_r <= ext_req;
                default: active_r <= 1'b0;
            endcase
        end
    end

    // Round-robin memory; reset as if DMA went last so the core starts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_dma_r <= 1'b1;
        end
        else if (boundary && owner_nxt == IARB_OWN_DMA && dma_req)
        begin
            last_dma_r <= 1'b1;
        end
        else if (boundary && owner_nxt == IARB_OWN_CORE && core_req)
        begin
            last_dma_r <= 1'b0;
        end
    end

    // Latched channel so the grant does not wander mid-transfer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dma_ch_r <= '0;
        end
        else if (boundary && owner_nxt == IARB_OWN_DMA)
        begin
            dma_ch_r <= dma_top;
        end
    end

    // Core-first window: armed when the grant returns, spent at the next boundary;
    // a return that falls on a boundary is used at once and arms nothing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bg_negated_d_r <= 1'b0;
            core_first_r <= 1'b0;
        end
        else
        begin
            bg_negated_d_r <= bg_negated;
            if (grant_back && !boundary)
            begin
                core_first_r <= 1'b1;
            end
            else if (boundary && !bg_negated)
            begin
                core_first_r <= 1'b0;
            end
        end
    end

    // Grants follow the owner only while it has a transfer running
    assign core_gnt = active_r && owner_r == IARB_OWN_CORE;
    assign dma_gnt = active_r && owner_r == IARB_OWN_DMA;
    assign ext_gnt = active_r && owner_r == IARB_OWN_EXT;
    assign dma_gnt_ch = dma_ch_r;

    // Register cycles go out only with arbitration on and the bus held
    assign int_xfer_ext = ext_arb_en && !external_bus_grant_in_n && core_gnt
        && core_int_reg;

    // Core waits on a register access while the external bus belongs to someone else
    assign core_stall = core_req && core_int_reg && ext_arb_en
        && external_bus_grant_in_n;

    // Show data is registered; bus controller must avoid fast termination next cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_data_r <= '0;
        end
        else
        begin
            ext_data_r <= int_reg_data;
        end
    end

    assign ext_data_out = ext_data_r;
    assign ext_data_oe = int_xfer_ext && show_en;

    // Drive acknowledge ourselves so nothing outside answers
    assign transfer_acknowledge_oe = int_xfer_ext;
    assign transfer_acknowledge_n_out = !int_xfer_ext;

    // Strobes held negated for a shown register cycle
    assign address_strobe_n = int_xfer_ext ? 1'b1 : address_strobe_n_in;
    assign chip_select_n = int_xfer_ext ? '1 : chip_select_n_in;

    // DMA counter width
    assign dma_count_width_select = ctrl_r[IARB_CNT24_BIT];
    assign dma_count_mask = ctrl_r[IARB_CNT24_BIT] ? IARB_MASK24 : IARB_MASK16;

endmodule

/* File: pkg/iarb_pkg.sv */
package iarb_pkg;
    localparam int IARB_AW = 8;
    localparam logic [IARB_AW-1:0] IARB_CTRL_OFS = 8'h0C;
    localparam logic [IARB_AW-1:0] IARB_STAT_OFS = 8'h10;
    localparam logic [7:0] IARB_CTRL_RST = 8'h00;
    localparam logic [7:0] IARB_CTRL_MASK = 8'hF9;
    localparam int IARB_SCHEME_HI = 7;
    localparam int IARB_SCHEME_LO = 6;
    localparam int IARB_INT_ARB_BIT = 5;
    localparam int IARB_EXT_ARB_BIT = 4;
    localparam int IARB_SHOW_BIT = 3;
    localparam int IARB_CNT24_BIT = 0;
    localparam logic [1:0] IARB_ROUND_ROBIN = 2'h0;
    localparam logic [1:0] IARB_PARK_CORE = 2'h1;
    localparam logic [1:0] IARB_PARK_DMA = 2'h2;
    localparam logic [1:0] IARB_PARK_CURRENT = 2'h3;
    localparam logic [2:0] IARB_BW_MAX = 3'h0;
    localparam int IARB_BW_W = 3;
    localparam logic [23:0] IARB_MASK16 = 24'h00FFFF;
    localparam logic [23:0] IARB_MASK24 = 24'hFFFFFF;
    typedef enum logic [1:0] {
        IARB_OWN_CORE = 2'b00,
        IARB_OWN_DMA = 2'b01,
        IARB_OWN_EXT = 2'b10
    } iarb_owner_e;
endpackage

/* File: verif/iarb_checker.sv */
module iarb_checker
    import iarb_pkg::*;
#(
    parameter int NUM_CS = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic core_req,
    input wire logic core_int_reg,
    input wire logic xfer_done,
    input wire logic external_bus_grant_in_n,
    input wire logic core_gnt,
    input wire logic dma_gnt,
    input wire logic ext_gnt,
    input wire logic core_stall,
    input wire logic ext_data_oe,
    input wire logic transfer_acknowledge_n_out,
    input wire logic transfer_acknowledge_oe,
    input wire logic address_strobe_n,
    input wire logic [NUM_CS-1:0] chip_select_n,
    input wire logic dma_count_width_select,
    input wire logic [23:0] dma_count_mask
);
    timeunit 1ns;
    timeprecision 1ns;

    // One clock domain, so clocking and reset are stated once
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Shown data only while a core register transfer is acknowledged
    a_show_needs_ack: assert property (
        ext_data_oe |-> transfer_acknowledge_oe && core_gnt)
        else $error("shown data without acknowledge");
    a_ack_driven_low: assert property (
        transfer_acknowledge_oe |->
        !transfer_acknowledge_n_out && core_int_reg && !external_bus_grant_in_n)
        else $error("acknowledge not asserted low");
    a_strobes_held: assert property (
        transfer_acknowledge_oe |-> address_strobe_n && (&chip_select_n))
        else $error("strobe asserted during shown transfer");
    a_count_mask: assert property (
        dma_count_mask == (dma_count_width_select ? IARB_MASK24 : IARB_MASK16))
        else $error("count mask wrong for width");
    // The core grant stands until its transfer ends
    a_grant_holds: assert property (core_gnt && !xfer_done |=> core_gnt)
        else $error("core grant dropped mid transfer");
    a_ext_needs_neg: assert property (
        $rose(ext_gnt) |-> $past(external_bus_grant_in_n))
        else $error("external master granted with grant asserted");
    a_stall_cause: assert property (
        core_stall |-> core_req && core_int_reg && external_bus_grant_in_n)
        else $error("stall without cause");
    a_one_owner: assert property ($onehot0({core_gnt, dma_gnt, ext_gnt}))
        else $error("two owners at once");
endmodule

bind iarb_internal_bus_master_arbiter iarb_checker #(.NUM_CS(NUM_CS)) u_chk (.*);

/* File: verif/iarb_internal_bus_master_arbiter_test.sv */
module iarb_internal_bus_master_arbiter_test;
    import iarb_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [1:0] sch;
        logic [2:0] bw;
        logic late;
        logic [5:0] seq;
        logic [1:0] ch;
    } iarb_row_s;

    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00, chip_select_n_in = 8'h00, chip_select_n;
    logic [31:0] pwdata = 32'h0, prdata, int_reg_data = 32'h0, ext_data_out, rd;
    logic core_req, core_int_reg = 0, ext_req, xfer_done, external_bus_grant_in_n = 0;
    logic [3:0] dma_ch_req;
    logic [11:0] dma_bandwidth_control = 12'h000;
    logic core_gnt, dma_gnt, ext_gnt, core_stall, ext_data_oe, address_strobe_n;
    logic transfer_acknowledge_n_out, transfer_acknowledge_oe, dma_count_width_select;
    logic address_strobe_n_in = 1'h0, core_want = 0, dma_want = 0, ext_want = 0, err;
    logic [1:0] dma_gnt_ch, ch;
    logic [23:0] dma_count_mask;
    logic [5:0] seq;
    int failures = 0, total_checks = 0;
    // Owner order per row, two bits a transfer: 0 core, 1 DMA, 2 external
    iarb_row_s rows [8] = '{'{2'h0, 3'h3, 1'h0, 6'h04, 2'h0}, '{2'h0, 3'h0, 1'h0, 6'h15, 2'h1},
        '{2'h1, 3'h3, 1'h0, 6'h00, 2'h0}, '{2'h2, 3'h1, 1'h0, 6'h15, 2'h1},
        '{2'h3, 3'h0, 1'h0, 6'h00, 2'h0}, '{2'h3, 3'h3, 1'h1, 6'h15, 2'h0},
        '{2'h1, 3'h3, 1'h1, 6'h05, 2'h0}, '{2'h0, 3'h2, 1'h0, 6'h04, 2'h0}};

    iarb_internal_bus_master_arbiter dut (.*);
    iarb_masters_model masters (.*);

    // Free-running bus clock
    initial
        forever #25 pclk = ~pclk;

    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic rst();
        presetn <= 1'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
    endtask

    // Idle edge first, so back-to-back calls never touch psel twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Owner of each of the next three transfers, taken at their closing edges
    task automatic run3(input logic late);
        int n;
        n = 0;
        ch = 2'h0;
        seq = 6'h3F;
        for (int i = 0; i < 60 && n < 3; i++)
        begin
            @(posedge pclk);
            if (xfer_done === 1'h1)
            begin
                seq[2*n +: 2] = {ext_gnt, dma_gnt};
                if (dma_gnt === 1'h1)
                    ch = dma_gnt_ch;
                if (late)
                    core_want <= 1'h1;
                n++;
            end
        end
    endtask

    // Hang guard, far beyond the few hundred cycles the run needs
    initial
    begin
        #1000000;
        failures++;
        test_done();
    end

    initial
    begin
        rst();
        apb(1'h0, IARB_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        chk(32'(dma_count_mask), 32'h00FFFF);
        // Status after reset: owner core, round-robin memory says DMA went last
        apb(1'h0, IARB_STAT_OFS, 32'h0);
        chk(rd, 32'h4);
        apb(1'h1, IARB_CTRL_OFS, 32'hFF);
        apb(1'h0, IARB_CTRL_OFS, 32'h0);
        chk(rd, 32'hF9);
        chk(32'(dma_count_mask), 32'hFFFFFF);
        chk(32'(dma_count_width_select), 32'h1);
        apb(1'h0, 8'h40, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        // Core against DMA, grant held low as in a single-master system;
        // late rows also switch external arbitration on, which must change nothing
        foreach (rows[i])
        begin
            rst();
            apb(1'h1, IARB_CTRL_OFS, {24'h0, rows[i].sch, 1'h0, rows[i].late, 4'h0});
            dma_bandwidth_control <= {6'h0, rows[i].bw, 3'h2};
            core_want <= !rows[i].late;
            dma_want <= 1'h1;
            run3(rows[i].late);
            chk(32'(seq), 32'(rows[i].seq));
            chk(32'(ch), 32'(rows[i].ch));
            core_want <= 1'h0;
            dma_want <= 1'h0;
        end
        // External master, then hand-back with DMA parked, showing on
        rst();
        apb(1'h1, IARB_CTRL_OFS, 32'h98);
        external_bus_grant_in_n <= 1'h1;
        core_int_reg <= 1'h1;
        int_reg_data <= 32'hA5C30F1E;
        {ext_want, core_want, dma_want} <= 3'h7;
        run3(1'h0);
        chk(32'(seq), 32'h2A);
        chk(32'(core_stall), 32'h1);
        ext_want <= 1'h0;
        run3(1'h0);
        chk(32'(seq), 32'h02);
        external_bus_grant_in_n <= 1'h0;
        run3(1'h0);
        chk(32'(seq), 32'h10);
        dma_want <= 1'h0;
        for (int i = 0; i < 20 && core_gnt !== 1'h1; i++) @(posedge pclk);
        chk(32'(ext_data_oe), 32'h1);
        chk(ext_data_out, 32'hA5C30F1E);
        chk({transfer_acknowledge_oe, transfer_acknowledge_n_out}, 32'h2);
        chk({address_strobe_n, chip_select_n}, 32'h1FF);
        apb(1'h1, IARB_CTRL_OFS, 32'h88);
        @(posedge pclk);
        chk(32'(ext_data_oe), 32'h0);
        chk({transfer_acknowledge_oe, address_strobe_n}, 32'h0);
        apb(1'h1, IARB_CTRL_OFS, 32'h90);
        @(posedge pclk);
        chk({ext_data_oe, transfer_acknowledge_oe}, 32'h1);
        test_done();
    end
endmodule

/* File: verif/iarb_masters_model.sv */
module iarb_masters_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic core_want,
    input wire logic dma_want,
    input wire logic ext_want,
    input wire logic core_gnt,
    input wire logic dma_gnt,
    input wire logic ext_gnt,
    output logic core_req,
    output logic [3:0] dma_ch_req,
    output logic ext_req,
    output logic xfer_done
);
    timeunit 1ns;
    timeprecision 1ns;

    logic half_r;

    // Two-cycle transfers that always end normally, never by fast termination
    assign xfer_done = (core_gnt | dma_gnt | ext_gnt) & half_r;
    // Plain level requests; two DMA channels ask so that ranking shows
    assign core_req = core_want;
    assign ext_req = ext_want;
    assign dma_ch_req = {2'h0, dma_want, dma_want};

    // Beat counter inside a granted transfer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            half_r <= 1'h0;
        else
            half_r <= (core_gnt | dma_gnt | ext_gnt) & !half_r;
    end
endmodule
